// [src/csr_core_regs.sv]
// core special registers: pointer, indirect port, work result, pc low,
// table registers and the flag register, behind a classic wishbone slave.
// assumes the execution logic and data memory share clk_i; data memory
// answers an indirect request with dmem_ack_i after any number of cycles.
//
// Behaviour
// - indirect port accesses go to the address held in the memory pointer
// - indirect port has no storage: through a pointer to itself it reads 00H, writes store nothing
// - memory pointer is an ordinary readable, writable register
// - indirect accesses reach data memory bank 0 only
// - work result register captures every alu result
// - no direct register-to-register move; data passes the work register
// - writing pc low jumps to that address within the current page
// - a pc low write inserts one dummy cycle
// - table read puts high word part in table high byte register
// - flag register writes leave sleep and dog flags unchanged
// - carry set on add carry-out or subtract without borrow; rotates too
// - nibble carry set on low nibble carry or no nibble borrow
// - null-result bit set when an arithmetic or logic result is zero
// - signed-wrap set when carry into and out of top bit differ
// - sleep flag: cleared at reset or refresh, set by sleep only
// - dog flag: cleared at reset, refresh or sleep; set on timeout
// - flag register never saved automatically on interrupt or call
// - flag register is 8 bits, six flags, top two bits read zero
// - unused special locations read 00H
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs
  import csr_pkg::*;
#(
  parameter int PC_W   = 10,
  parameter int TBL_W  = 14,
  parameter int ADR_W  = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // execution logic
  input  wire logic              alu_valid_i,
  input  wire logic [3:0]        alu_op_i,
  input  wire logic [7:0]        alu_a_i,
  input  wire logic [7:0]        alu_b_i,
  input  wire logic              sleep_instr_i,
  input  wire logic              dog_refresh_instr_i,
  input  wire logic              dog_timeout_i,
  input  wire logic              table_read_i,
  input  wire logic [TBL_W-1:0]  table_word_i,
  input  wire logic [PC_W-1:0]   pc_cur_i,
  output logic      [7:0]        work_result_o,
  output logic      [7:0]        flag_o,
  output logic      [7:0]        memory_pointer_o,
  output logic      [15:0]       table_addr_o,
  output logic      [7:0]        table_low_o,
  output logic                   pc_jump_o,
  output logic      [PC_W-1:0]   pc_target_o,
  output logic                   dummy_cycle_o,
  // data memory, bank 0
  output logic                   dmem_req_o,
  output logic                   dmem_we_o,
  output logic      [7:0]        dmem_addr_o,
  output logic      [7:0]        dmem_wdata_o,
  output logic                   dmem_bank_o,
  input  wire logic [7:0]        dmem_rdata_i,
  input  wire logic              dmem_ack_i
);

  // add with carry in; returns {carry, nibble carry, wrap, sum}
  function automatic logic [10:0] alu_sum(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
    logic [4:0] low;
    logic [7:0] mid;
    logic [8:0] full;
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    mid  = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    alu_sum = {full[8], low[4], full[8] ^ mid[7], full[7:0]};
  endfunction

  // register state
  logic [7:0]      memory_pointer;
  logic [7:0]      work_result_reg;
  logic [7:0]      table_ptr_low;
  logic [7:0]      table_ptr_high;
  logic [7:0]      table_high_byte;
  logic [7:0]      flag_register;
  csr_state_t      state;
  logic [7:0]      next_memory_pointer;
  logic [7:0]      next_work_result_reg;
  logic [7:0]      next_table_ptr_low;
  logic [7:0]      next_table_ptr_high;
  logic [7:0]      next_table_high_byte;
  logic [7:0]      next_flag_register;
  csr_state_t      next_state;
  logic [31:0]     next_dat;
  logic            next_ack;
  logic [7:0]      next_table_low;
  logic            next_pc_jump;
  logic [PC_W-1:0] next_pc_target;
  logic            next_dummy;
  logic            next_dmem_req;
  logic            next_dmem_we;
  logic [7:0]      next_dmem_addr;
  logic [7:0]      next_dmem_wdata;

  // local register read, shared by direct and indirect paths
  function automatic logic [7:0] sfr_read(input logic [5:0] idx,
                                          input logic [7:0] ptr,
                                          input logic [7:0] work,
                                          input logic [7:0] pc_low_byte,
                                          input logic [7:0] tpl,
                                          input logic [7:0] tbh,
                                          input logic [7:0] tph,
                                          input logic [7:0] flg);
    case (idx)
      IDX_INDIRECT:  sfr_read = BYTE_ZERO;
      IDX_POINTER:   sfr_read = ptr;
      IDX_WORK:      sfr_read = work;
      IDX_PC_LOW:    sfr_read = pc_low_byte;
      IDX_TPTR_LOW:  sfr_read = tpl;
      IDX_TBL_HIGH:  sfr_read = tbh;
      IDX_TPTR_HIGH: sfr_read = tph;
      IDX_FLAG:      sfr_read = flg & FLAG_IMPL;
      default:       sfr_read = BYTE_ZERO;
    endcase
  endfunction

  // bus request decode
  logic       bus_new;
  logic [5:0] bus_idx;
  logic       to_indirect;
  logic       ptr_external;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx_data;
  logic [10:0] sum;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_nc;
  logic       alu_wrap;
  logic       arith;
  logic       logic_op;
  logic       rotate;

  always_comb begin
    bus_new      = cyc_i && stb_i && !ack_o && (state == CSR_IDLE);
    bus_idx      = adr_i[7:2];
    to_indirect  = (bus_idx == IDX_INDIRECT);
    // pointer at the special area stays on chip; above it goes to ram
    ptr_external = (memory_pointer >= SFR_LIMIT);
    // an indirect access is redirected to the pointed location
    wr_idx       = to_indirect ? memory_pointer[5:0] : bus_idx;
    wr_data      = dat_i[7:0];
    // writing through a pointer that names the port itself does nothing
    wr_en        = bus_new && we_i && sel_i[0] &&
                   !(to_indirect && ptr_external) &&
                   (wr_idx != IDX_INDIRECT);
    rd_idx_data  = sfr_read(wr_idx, memory_pointer, work_result_reg,
                            pc_cur_i[7:0], table_ptr_low, table_high_byte,
                            table_ptr_high, flag_register);
  end

  // alu
  always_comb begin
    sum      = 11'h000;
    alu_res  = alu_a_i;
    alu_c    = flag_register[FB_CARRY];
    alu_nc   = flag_register[FB_NIBBLE];
    alu_wrap = flag_register[FB_WRAP];
    arith    = 1'b0;
    logic_op = 1'b0;
    rotate   = 1'b0;
    case (alu_op_i)
      CSR_OP_ADD: begin
        sum   = alu_sum(alu_a_i, alu_b_i, 1'b0);
        arith = 1'b1;
      end
      CSR_OP_ADC: begin
        sum   = alu_sum(alu_a_i, alu_b_i, flag_register[FB_CARRY]);
        arith = 1'b1;
      end
      // subtraction as a + ~b + 1: carry out means no borrow
      CSR_OP_SUB: begin
        sum   = alu_sum(alu_a_i, ~alu_b_i, 1'b1);
        arith = 1'b1;
      end
      CSR_OP_SBC: begin
        sum   = alu_sum(alu_a_i, ~alu_b_i, flag_register[FB_CARRY]);
        arith = 1'b1;
      end
      CSR_OP_AND: begin
        alu_res  = alu_a_i & alu_b_i;
        logic_op = 1'b1;
      end
      CSR_OP_OR: begin
        alu_res  = alu_a_i | alu_b_i;
        logic_op = 1'b1;
      end
      CSR_OP_XOR: begin
        alu_res  = alu_a_i ^ alu_b_i;
        logic_op = 1'b1;
      end
      CSR_OP_RLC: begin
        alu_res = {alu_a_i[6:0], flag_register[FB_CARRY]};
        alu_c   = alu_a_i[7];
        rotate  = 1'b1;
      end
      CSR_OP_RRC: begin
        alu_res = {flag_register[FB_CARRY], alu_a_i[7:1]};
        alu_c   = alu_a_i[0];
        rotate  = 1'b1;
      end
      CSR_OP_PASS: alu_res = alu_a_i;
      default:     alu_res = alu_a_i;
    endcase
    if (arith) begin
      alu_res  = sum[7:0];
      alu_c    = sum[10];
      alu_nc   = sum[9];
      alu_wrap = sum[8];
    end
  end

  // register next values
  always_comb begin
    next_memory_pointer  = memory_pointer;
    next_work_result_reg = work_result_reg;
    next_table_ptr_low   = table_ptr_low;
    next_table_ptr_high  = table_ptr_high;
    next_table_high_byte = table_high_byte;
    next_flag_register   = flag_register;
    next_table_low       = table_low_o;
    next_pc_jump         = 1'b0;
    next_pc_target       = pc_target_o;
    // dummy cycle follows the jump pulse by one cycle
    next_dummy           = pc_jump_o;
    if (wr_en) begin
      case (wr_idx)
        // increments arrive as read, alu, write back like any register
        IDX_POINTER:   next_memory_pointer = wr_data;
        IDX_WORK:      next_work_result_reg = wr_data;
        IDX_PC_LOW: begin
          next_pc_jump   = 1'b1;
          next_pc_target = {pc_cur_i[PC_W-1:8], wr_data};
        end
        IDX_TPTR_LOW:  next_table_ptr_low = wr_data;
        IDX_TBL_HIGH:  next_table_high_byte = wr_data;
        IDX_TPTR_HIGH: next_table_ptr_high = wr_data;
        IDX_FLAG: begin
          next_flag_register = (flag_register & ~FLAG_WR_MASK) |
                               (wr_data & FLAG_WR_MASK);
        end
        default:       next_memory_pointer = memory_pointer;
      endcase
    end
    // the only alu destination is the work register; a move between two
    // user registers must be a bus read, alu pass, bus write pair
    if (alu_valid_i) begin
      next_work_result_reg = alu_res;
      if (arith || logic_op) begin
        next_flag_register[FB_NULL] = (alu_res == BYTE_ZERO);
      end
      if (arith || rotate) begin
        next_flag_register[FB_CARRY] = alu_c;
      end
      if (arith) begin
        next_flag_register[FB_NIBBLE] = alu_nc;
        next_flag_register[FB_WRAP]   = alu_wrap;
      end
    end
    if (table_read_i) begin
      next_table_high_byte = {{(16-TBL_W){1'b0}},
                              table_word_i[TBL_W-1:TBL_HI_LSB]};
      next_table_low       = table_word_i[7:0];
    end
    // system flags: clears first so that a same-cycle set wins
    if (dog_refresh_instr_i) begin
      next_flag_register[FB_SLEEP] = 1'b0;
      next_flag_register[FB_DOG]   = 1'b0;
    end
    if (sleep_instr_i) begin
      next_flag_register[FB_DOG]   = 1'b0;
      next_flag_register[FB_SLEEP] = 1'b1;
    end
    if (dog_timeout_i) begin
      next_flag_register[FB_DOG] = 1'b1;
    end
    next_flag_register = next_flag_register & FLAG_IMPL;
  end

  // bus and data memory sequencing
  always_comb begin
    next_state      = state;
    next_ack        = 1'b0;
    next_dat        = dat_o;
    next_dmem_req   = dmem_req_o;
    next_dmem_we    = dmem_we_o;
    next_dmem_addr  = dmem_addr_o;
    next_dmem_wdata = dmem_wdata_o;
    case (state)
      CSR_IDLE: begin
        if (bus_new) begin
          if (to_indirect && ptr_external) begin
            next_state      = CSR_MEM;
            next_dmem_req   = 1'b1;
            next_dmem_we    = we_i && sel_i[0];
            next_dmem_addr  = memory_pointer;
            next_dmem_wdata = dat_i[7:0];
          end else begin
            next_ack = 1'b1;
            next_dat = {24'h000000, rd_idx_data};
          end
        end
      end
      CSR_MEM: begin
        if (dmem_ack_i) begin
          next_state    = CSR_IDLE;
          next_dmem_req = 1'b0;
          next_dmem_we  = 1'b0;
          next_ack      = 1'b1;
          next_dat      = {24'h000000, dmem_rdata_i};
        end
      end
      default: next_state = CSR_IDLE;
    endcase
  end

  // nothing here stacks the flag register; entry logic sees flag_o only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      memory_pointer  <= REG_RST;
      work_result_reg <= REG_RST;
      table_ptr_low   <= REG_RST;
      table_ptr_high  <= REG_RST;
      table_high_byte <= REG_RST;
      flag_register   <= FLAG_RST;
      state           <= CSR_IDLE;
      dat_o           <= 32'h00000000;
      ack_o           <= 1'b0;
      table_low_o     <= REG_RST;
      pc_jump_o       <= 1'b0;
      pc_target_o     <= '0;
      dummy_cycle_o   <= 1'b0;
      dmem_req_o      <= 1'b0;
      dmem_we_o       <= 1'b0;
      dmem_addr_o     <= REG_RST;
      dmem_wdata_o    <= REG_RST;
    end else begin
      memory_pointer  <= next_memory_pointer;
      work_result_reg <= next_work_result_reg;
      table_ptr_low   <= next_table_ptr_low;
      table_ptr_high  <= next_table_ptr_high;
      table_high_byte <= next_table_high_byte;
      flag_register   <= next_flag_register;
      state           <= next_state;
      dat_o           <= next_dat;
      ack_o           <= next_ack;
      table_low_o     <= next_table_low;
      pc_jump_o       <= next_pc_jump;
      pc_target_o     <= next_pc_target;
      dummy_cycle_o   <= next_dummy;
      dmem_req_o      <= next_dmem_req;
      dmem_we_o       <= next_dmem_we;
      dmem_addr_o     <= next_dmem_addr;
      dmem_wdata_o    <= next_dmem_wdata;
    end
  end

  // mirrors of register state, each one flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_result_o    <= REG_RST;
      flag_o           <= FLAG_RST;
      memory_pointer_o <= REG_RST;
      table_addr_o     <= 16'h0000;
      dmem_bank_o      <= 1'b0;
    end else begin
      work_result_o    <= next_work_result_reg;
      flag_o           <= next_flag_register;
      memory_pointer_o <= next_memory_pointer;
      table_addr_o     <= {next_table_ptr_high, next_table_ptr_low};
      dmem_bank_o      <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [src/csr_pkg.sv]
// core special register block: shared constants and types
// assumes a 32-bit classic wishbone bus with one register per aligned word
package csr_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_INDIRECT  = 6'h00;
  localparam logic [5:0] IDX_POINTER   = 6'h01;
  localparam logic [5:0] IDX_WORK      = 6'h05;
  localparam logic [5:0] IDX_PC_LOW    = 6'h06;
  localparam logic [5:0] IDX_TPTR_LOW  = 6'h07;
  localparam logic [5:0] IDX_TBL_HIGH  = 6'h08;
  localparam logic [5:0] IDX_TPTR_HIGH = 6'h09;
  localparam logic [5:0] IDX_FLAG      = 6'h0a;

  // pointer values below this reach the special register area itself
  localparam logic [7:0] SFR_LIMIT = 8'h40;

  // flag register bit positions
  localparam int FB_CARRY  = 0;
  localparam int FB_NIBBLE = 1;
  localparam int FB_NULL   = 2;
  localparam int FB_WRAP   = 3;
  localparam int FB_SLEEP  = 4;
  localparam int FB_DOG    = 5;

  localparam logic [7:0] FLAG_WR_MASK = 8'h0f;
  localparam logic [7:0] FLAG_IMPL    = 8'h3f;
  localparam logic [7:0] FLAG_RST     = 8'h00;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam int         TBL_HI_LSB   = 8;

  typedef enum logic [1:0] {
    CSR_IDLE = 2'b00,
    CSR_MEM  = 2'b01
  } csr_state_t;

  typedef enum logic [3:0] {
    CSR_OP_ADD  = 4'h0,
    CSR_OP_ADC  = 4'h1,
    CSR_OP_SUB  = 4'h2,
    CSR_OP_SBC  = 4'h3,
    CSR_OP_AND  = 4'h4,
    CSR_OP_OR   = 4'h5,
    CSR_OP_XOR  = 4'h6,
    CSR_OP_RLC  = 4'h7,
    CSR_OP_RRC  = 4'h8,
    CSR_OP_PASS = 4'h9
  } csr_op_t;

endpackage

// [tb/csr_core_regs_asserts.sv]
// port assertions for csr_core_regs, bound to every instance
// one clock domain, synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_asserts
  import csr_pkg::*;
#(
  parameter int PC_W  = 10,
  parameter int ADR_W = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [31:0]      dat_i,
  input wire logic             ack_o,
  input wire logic             alu_valid_i,
  input wire logic [3:0]       alu_op_i,
  input wire logic             sleep_instr_i,
  input wire logic             dog_refresh_instr_i,
  input wire logic             dog_timeout_i,
  input wire logic [PC_W-1:0]  pc_cur_i,
  input wire logic [7:0]       work_result_o,
  input wire logic [7:0]       flag_o,
  input wire logic [7:0]       memory_pointer_o,
  input wire logic             pc_jump_o,
  input wire logic [PC_W-1:0]  pc_target_o,
  input wire logic             dummy_cycle_o,
  input wire logic             dmem_req_o,
  input wire logic [7:0]       dmem_addr_o,
  input wire logic             dmem_bank_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bank_zero: assert property (dmem_bank_o == 1'b0)
    else $error("bank not zero");
  a_local_ack:
    assert property ($rose(cyc_i && stb_i) && adr_i[ADR_W-1:2] != IDX_INDIRECT
      |=> ack_o ##1 !ack_o) else $error("local answer late");
  a_pc_jump:
    assert property ($rose(cyc_i && stb_i) && we_i && sel_i[0] && adr_i[ADR_W-1:2] == IDX_PC_LOW
      |=> pc_jump_o && pc_target_o == {pc_cur_i[PC_W-1:8], $past(dat_i[7:0])})
    else $error("bad jump");
  a_one_dummy: assert property (pc_jump_o |=> dummy_cycle_o ##1 !dummy_cycle_o)
    else $error("bad dummy cycle");
  a_ind_addr: assert property ($rose(dmem_req_o) |-> dmem_addr_o == memory_pointer_o)
    else $error("address not pointer");
  a_flag_top: assert property (flag_o[7:6] == 2'b00)
    else $error("flag top bits set");
  a_sleep_set:
    assert property (sleep_instr_i && !dog_timeout_i |=> flag_o[FB_SLEEP] && !flag_o[FB_DOG])
    else $error("sleep flags wrong");
  a_flag_keep:
    assert property (!(sleep_instr_i || dog_refresh_instr_i || dog_timeout_i)
      |=> $stable(flag_o[FB_DOG:FB_SLEEP])) else $error("system flags moved");
  a_refresh_clr:
    assert property (dog_refresh_instr_i && !sleep_instr_i && !dog_timeout_i
      |=> flag_o[FB_DOG:FB_SLEEP] == 2'b00) else $error("refresh kept flags");
  a_null_bit:
    assert property (alu_valid_i && alu_op_i <= 4'h6
      |=> flag_o[FB_NULL] == (work_result_o == 8'h00)) else $error("null bit wrong");
endmodule
bind csr_core_regs csr_core_regs_asserts #(.PC_W(PC_W), .ADR_W(ADR_W)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .alu_valid_i(alu_valid_i),
  .alu_op_i(alu_op_i), .sleep_instr_i(sleep_instr_i), .dog_refresh_instr_i(dog_refresh_instr_i),
  .dog_timeout_i(dog_timeout_i), .pc_cur_i(pc_cur_i), .work_result_o(work_result_o),
  .flag_o(flag_o), .memory_pointer_o(memory_pointer_o), .pc_jump_o(pc_jump_o),
  .pc_target_o(pc_target_o), .dummy_cycle_o(dummy_cycle_o), .dmem_req_o(dmem_req_o),
  .dmem_addr_o(dmem_addr_o), .dmem_bank_o(dmem_bank_o));
`default_nettype wire

// [tb/csr_dmem_model.sv]
// data memory model serving the block's bank 0 requests
// same clock as the block; answer delay set by the bench
`timescale 1ns/1ps
`default_nettype none
module csr_dmem_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic       we_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] lat_i,
  output logic      [7:0] rdata_o,
  output logic            ack_o
);
  logic [7:0] mem [256];
  logic [7:0] cnt;
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    // data only valid with the answer, toggles otherwise
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      cnt <= 8'h00;
      rdata_o <= 8'h00;
    end else if (req_i && !ack_o) begin
      if (cnt == lat_i) begin
        cnt <= 8'h00;
        ack_o <= 1'b1;
        rdata_o <= mem[addr_i];
        if (we_i) begin
          mem[addr_i] <= wdata_i;
        end
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/csr_core_regs_test.sv]
// self-checking bench for csr_core_regs with a data memory model
// inputs change by nonblocking writes at rising edges of an 8 ns clock
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_test;
  import csr_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} csr_reg_row_t;
  typedef struct packed {
    logic [3:0] op; logic [7:0] a; logic [7:0] b; logic [7:0] r; logic [7:0] f;
  } csr_alu_row_t;
  localparam csr_reg_row_t reg_rows [8] = '{
    '{8'h04, 8'h5a, 8'h5a}, '{8'h14, 8'h3c, 8'h3c}, '{8'h1c, 8'h12, 8'h12},
    '{8'h24, 8'h03, 8'h03}, '{8'h20, 8'h7e, 8'h7e}, '{8'h28, 8'hff, 8'h0f},
    '{8'h08, 8'h55, 8'h00}, '{8'hfc, 8'h77, 8'h00}};
  localparam csr_alu_row_t alu_rows [11] = '{
    '{4'h0, 8'hff, 8'h01, 8'h00, 8'h07}, '{4'h1, 8'h7f, 8'h00, 8'h80, 8'h0a},
    '{4'h2, 8'h10, 8'h01, 8'h0f, 8'h01}, '{4'h3, 8'h80, 8'h01, 8'h7f, 8'h09},
    '{4'h4, 8'hf0, 8'h0f, 8'h00, 8'h0d}, '{4'h5, 8'h21, 8'h02, 8'h23, 8'h09},
    '{4'h6, 8'h5a, 8'h5a, 8'h00, 8'h0d}, '{4'h7, 8'h01, 8'h00, 8'h03, 8'h0c},
    '{4'h8, 8'h01, 8'h00, 8'h00, 8'h0d}, '{4'h9, 8'h00, 8'hff, 8'h00, 8'h0d},
    '{4'hf, 8'h42, 8'h00, 8'h42, 8'h0d}};
  // sleep, refresh, timeout pulse with the flag value it should leave
  localparam logic [10:0] ev_rows [5] = '{
    {3'b100, 8'h1d}, {3'b001, 8'h3d}, {3'b010, 8'h0d}, {3'b101, 8'h3d}, {3'b100, 8'h1d}};
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic alu_valid_i = 1'b0, sleep_instr_i = 1'b0, dog_refresh_instr_i = 1'b0;
  logic dog_timeout_i = 1'b0, table_read_i = 1'b0;
  logic [7:0] adr_i = 8'h00, alu_a_i = 8'h00, alu_b_i = 8'h00, lat = 8'h00, q;
  logic [3:0] sel_i = 4'h1, alu_op_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000, dat_o;
  logic [13:0] table_word_i = 14'h0000;
  logic [9:0] pc_cur_i = 10'h2c5, pc_target_o;
  logic ack_o, pc_jump_o, dummy_cycle_o, dmem_req_o, dmem_we_o, dmem_bank_o, dmem_ack_i;
  logic [7:0] work_result_o, flag_o, memory_pointer_o, table_low_o;
  logic [7:0] dmem_addr_o, dmem_wdata_o, dmem_rdata_i;
  logic [15:0] table_addr_o;
  int errors = 0, n_checks = 0;
  csr_core_regs i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .alu_valid_i(alu_valid_i),
    .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .sleep_instr_i(sleep_instr_i),
    .dog_refresh_instr_i(dog_refresh_instr_i), .dog_timeout_i(dog_timeout_i),
    .table_read_i(table_read_i), .table_word_i(table_word_i), .pc_cur_i(pc_cur_i),
    .work_result_o(work_result_o), .flag_o(flag_o), .memory_pointer_o(memory_pointer_o),
    .table_addr_o(table_addr_o), .table_low_o(table_low_o), .pc_jump_o(pc_jump_o),
    .pc_target_o(pc_target_o), .dummy_cycle_o(dummy_cycle_o), .dmem_req_o(dmem_req_o),
    .dmem_we_o(dmem_we_o), .dmem_addr_o(dmem_addr_o), .dmem_wdata_o(dmem_wdata_o),
    .dmem_bank_o(dmem_bank_o), .dmem_rdata_i(dmem_rdata_i), .dmem_ack_i(dmem_ack_i));
  csr_dmem_model i_mem (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(dmem_req_o), .we_i(dmem_we_o), .addr_i(dmem_addr_o),
    .wdata_i(dmem_wdata_o), .lat_i(lat), .rdata_o(dmem_rdata_i), .ack_o(dmem_ack_i));
  always #4 clk_i = ~clk_i;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic ev(input logic [2:0] e);
    @(posedge clk_i);
    {sleep_instr_i, dog_refresh_instr_i, dog_timeout_i} <= e;
    @(posedge clk_i);
    {sleep_instr_i, dog_refresh_instr_i, dog_timeout_i} <= 3'b000;
    #1;
  endtask
  task automatic alu_op(input csr_alu_row_t w);
    @(posedge clk_i);
    alu_valid_i <= 1'b1;
    alu_op_i <= w.op;
    alu_a_i <= w.a;
    alu_b_i <= w.b;
    @(posedge clk_i);
    alu_valid_i <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("flag", 8'h00, flag_o);
    $display("done reset");
    foreach (reg_rows[i]) begin
      wb(1'b1, reg_rows[i].a, reg_rows[i].d, q);
      wb(1'b0, reg_rows[i].a, 8'h00, q);
      chk("register", reg_rows[i].e, q);
    end
    chk("table address", 16'h0312, table_addr_o);
    $display("done registers");
    foreach (alu_rows[i]) begin
      alu_op(alu_rows[i]);
      chk("work", alu_rows[i].r, work_result_o);
      chk("flag", alu_rows[i].f, flag_o);
    end
    $display("done alu");
    foreach (ev_rows[i]) begin
      ev(ev_rows[i][10:8]);
      chk("flag", ev_rows[i][7:0], flag_o);
    end
    wb(1'b1, 8'h28, 8'h00, q);
    chk("flag", 8'h10, flag_o);
    $display("done flags");
    wb(1'b1, 8'h04, 8'h05, q);
    wb(1'b1, 8'h00, 8'h99, q);
    wb(1'b0, 8'h14, 8'h00, q);
    chk("work via pointer", 8'h99, q);
    // lane 0 disabled: the write must be dropped
    sel_i <= 4'h0;
    wb(1'b1, 8'h14, 8'h66, q);
    sel_i <= 4'h1;
    wb(1'b0, 8'h14, 8'h00, q);
    chk("masked write", 8'h99, q);
    wb(1'b1, 8'h04, 8'h00, q);
    wb(1'b1, 8'h00, 8'h55, q);
    wb(1'b0, 8'h00, 8'h00, q);
    chk("indirect self", 8'h00, q);
    for (int i = 0; i < 2; i++) begin
      lat <= 8'(6 * i);
      wb(1'b1, 8'h04, 8'h45 + 8'(i), q);
      wb(1'b1, 8'h00, 8'ha7 + 8'(i), q);
      wb(1'b0, 8'h00, 8'h00, q);
      chk("indirect memory", 8'ha7 + 8'(i), q);
      chk("bank", 1'b0, dmem_bank_o);
    end
    $display("done indirect");
    wb(1'b1, 8'h18, 8'h3b, q);
    chk("jump target", 10'h23b, pc_target_o);
    // pulse launched at the taking edge, still standing at the ack edge
    chk("jump pulse", 1'b1, pc_jump_o);
    #1;
    chk("dummy cycle", 1'b1, dummy_cycle_o);
    chk("jump pulse end", 1'b0, pc_jump_o);
    wb(1'b0, 8'h18, 8'h00, q);
    chk("pc low", 8'hc5, q);
    @(posedge clk_i);
    table_read_i <= 1'b1;
    table_word_i <= 14'h2abc;
    @(posedge clk_i);
    table_read_i <= 1'b0;
    #1;
    chk("table low", 8'hbc, table_low_o);
    wb(1'b0, 8'h20, 8'h00, q);
    chk("table high", 8'h2a, q);
    $display("done jump and table");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("flag after reset", 8'h00, flag_o);
    chk("pointer after reset", 8'h00, memory_pointer_o);
    $display("done second reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
